// ---- rtl/ldoreg_bank.v ----
/*
 * Register bank for four low-dropout regulators (H, I, J, K): voltage
 * and control registers, sticky fault status, mask and interrupt line.
 * Assumes a plain one-cycle strobe register port on core_clk; power-good
 * and fault levels arrive asynchronously from the analog side.
 */
// Behaviour
// R1: Voltage register holds a six-bit read/write output level code in bits 5:0.
// R2: Control bit 7 enables the regulator and reads back as written.
// R3: Control bit 2 set applies output discharge while the regulator is off.
// R4: Control bit 1 lets a regulator fault raise an interrupt; 0 suppresses it.
// R5: Control bit 0 is read-only power-good; writes do not affect it.
// R6: Reserved bits read zero; writes to them change nothing.
`timescale 1ns/100ps
`include "ldoreg_defines.vh"

module ldoreg_bank #(
	parameter NCH = 4
) (
	core_clk,
	arst_n,
	addr,
	wdata,
	wr,
	rd,
	rdata,
	pgood_in,
	fault_in,
	reg_enable,
	reg_discharge,
	irq
);
	input  wire            core_clk;
	input  wire            arst_n;
	input  wire [7:0]      addr;
	input  wire [7:0]      wdata;
	input  wire            wr;
	input  wire            rd;
	output reg  [7:0]      rdata;
	input  wire [NCH-1:0]  pgood_in;
	input  wire [NCH-1:0]  fault_in;
	output reg  [NCH-1:0]  reg_enable;
	output reg  [NCH-1:0]  reg_discharge;
	output reg             irq;

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	reg  [NCH-1:0] pg_s1_r;
	reg  [NCH-1:0] pg_s2_r;
	reg  [NCH-1:0] ft_s1_r;
	reg  [NCH-1:0] ft_s2_r;

	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			pg_s1_r <= {NCH{1'b0}};
			pg_s2_r <= {NCH{1'b0}};
			ft_s1_r <= {NCH{1'b0}};
			ft_s2_r <= {NCH{1'b0}};
		end else begin
			pg_s1_r <= pgood_in;
			pg_s2_r <= pg_s1_r;
			ft_s1_r <= fault_in;
			ft_s2_r <= ft_s1_r;
		end
	end

	// ----------------------------------------
	// Channel offsets and decode
	// ----------------------------------------
	wire [8*NCH-1:0] volt_off;
	wire [8*NCH-1:0] ctrl_off;
	assign volt_off = {`LDOREG_OFF_K_VOLT, `LDOREG_OFF_J_VOLT,
	                   `LDOREG_OFF_I_VOLT, `LDOREG_OFF_H_VOLT};
	assign ctrl_off = {`LDOREG_OFF_K_CTRL, `LDOREG_OFF_J_CTRL,
	                   `LDOREG_OFF_I_CTRL, `LDOREG_OFF_H_CTRL};

	wire [8*NCH-1:0] volt_rd;
	wire [8*NCH-1:0] ctrl_rd;
	wire [NCH-1:0]   en_w;
	wire [NCH-1:0]   dis_w;
	wire [NCH-1:0]   evt_w;
	wire [NCH-1:0]   volt_hit;
	wire [NCH-1:0]   ctrl_hit;

	genvar g;
	generate
		for (g = 0; g < NCH; g = g + 1) begin : g_ch
			assign volt_hit[g] = (addr == volt_off[8*g+7:8*g]);
			assign ctrl_hit[g] = (addr == ctrl_off[8*g+7:8*g]);
			ldoreg_channel u_ch (
				.core_clk  (core_clk),
				.arst_n    (arst_n),
				.volt_we   (wr & volt_hit[g]),
				.ctrl_we   (wr & ctrl_hit[g]),
				.wdata     (wdata),
				.pgood     (pg_s2_r[g]),
				.fault     (ft_s2_r[g]),
				.volt_rd   (volt_rd[8*g+7:8*g]),
				.ctrl_rd   (ctrl_rd[8*g+7:8*g]),
				.enable    (en_w[g]),
				.discharge (dis_w[g]),
				.fault_evt (evt_w[g])
			);
		end
	endgenerate

	// ----------------------------------------
	// Interrupt status and mask
	// ----------------------------------------
	reg  [NCH-1:0] irq_stat_r;
	reg  [NCH-1:0] irq_mask_r;
	wire           stat_hit;
	wire           mask_hit;
	wire [NCH-1:0] stat_nxt;

	assign stat_hit = (addr == `LDOREG_OFF_IRQ_STAT);
	assign mask_hit = (addr == `LDOREG_OFF_IRQ_MASK);
	// A new event wins over a write-one-to-clear in the same cycle
	assign stat_nxt = (irq_stat_r & ~({NCH{wr & stat_hit}} & wdata[NCH-1:0])) | evt_w; // [R4]

	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_stat_r <= {NCH{1'b0}};
			irq_mask_r <= {NCH{1'b0}};
		end else begin
			irq_stat_r <= stat_nxt;
			if (wr & mask_hit) begin
				irq_mask_r <= wdata[NCH-1:0];
			end
		end
	end

	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	reg [7:0] rd_nxt;
	integer i;

	always @* begin
		rd_nxt = `LDOREG_BYTE_ZERO;
		for (i = 0; i < NCH; i = i + 1) begin
			if (volt_hit[i]) begin
				rd_nxt = volt_rd[8*i +: 8]; // [R1]
			end
			if (ctrl_hit[i]) begin
				rd_nxt = ctrl_rd[8*i +: 8]; // [R5]
			end
		end
		if (stat_hit) begin
			rd_nxt = `LDOREG_BYTE_ZERO;
			rd_nxt[NCH-1:0] = irq_stat_r;
		end
		if (mask_hit) begin
			rd_nxt = `LDOREG_BYTE_ZERO;
			rd_nxt[NCH-1:0] = irq_mask_r;
		end
	end

	// ----------------------------------------
	// Registered outputs
	// ----------------------------------------
	// Read data is held only for the cycle after the strobe; zero otherwise
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata         <= `LDOREG_BYTE_ZERO;
			reg_enable    <= {NCH{1'b0}};
			reg_discharge <= {NCH{1'b0}};
			irq           <= 1'b0;
		end else begin
			rdata         <= rd ? rd_nxt : `LDOREG_BYTE_ZERO;
			reg_enable    <= en_w;  // [R2]
			reg_discharge <= dis_w; // [R3]
			irq           <= |(stat_nxt & irq_mask_r);
		end
	end
endmodule

// ---- rtl/ldoreg_defines.vh ----
/*
 * Constants for the regulator control register bank: offsets, field
 * positions, reset values and the interrupt register offsets.
 * Assumes inclusion by bare name from the bank's design files.
 */
`ifndef LDOREG_DEFINES_VH
`define LDOREG_DEFINES_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define LDOREG_ADDR_W          8
`define LDOREG_OFF_H_CTRL      8'h69
`define LDOREG_OFF_I_VOLT      8'h70
`define LDOREG_OFF_I_CTRL      8'h71
`define LDOREG_OFF_J_VOLT      8'h80
`define LDOREG_OFF_J_CTRL      8'h81
`define LDOREG_OFF_K_VOLT      8'h90
`define LDOREG_OFF_K_CTRL      8'h91
`define LDOREG_OFF_H_VOLT      8'h68
`define LDOREG_OFF_IRQ_STAT    8'hE0
`define LDOREG_OFF_IRQ_MASK    8'hE1

// ----------------------------------------
// Field positions
// ----------------------------------------
`define LDOREG_VOLT_MSB        5
`define LDOREG_CTRL_ON         7
`define LDOREG_CTRL_DIS        2
`define LDOREG_CTRL_FIE        1
`define LDOREG_CTRL_PG         0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define LDOREG_VOLT_RST        6'h00
`define LDOREG_BYTE_ZERO       8'h00

`endif

// ---- rtl/ldoreg_channel.v ----
/*
 * One regulator's voltage and control fields plus its fault-event flag.
 * Assumes the caller supplies decoded write strobes and synchronised
 * power-good and fault levels on core_clk.
 */
`timescale 1ns/100ps
`include "ldoreg_defines.vh"

module ldoreg_channel (
	core_clk,
	arst_n,
	volt_we,
	ctrl_we,
	wdata,
	pgood,
	fault,
	volt_rd,
	ctrl_rd,
	enable,
	discharge,
	fault_evt
);
	input  wire       core_clk;
	input  wire       arst_n;
	input  wire       volt_we;
	input  wire       ctrl_we;
	input  wire [7:0] wdata;
	input  wire       pgood;
	input  wire       fault;
	output wire [7:0] volt_rd;
	output wire [7:0] ctrl_rd;
	output wire       enable;
	output wire       discharge;
	output wire       fault_evt;

	reg  [5:0] output_level_code_r;
	reg        on_r;
	reg        shutdown_discharge_enable_r;
	reg        fault_irq_enable_r;
	reg        fault_d_r;

	// ----------------------------------------
	// Field storage
	// ----------------------------------------
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			output_level_code_r         <= `LDOREG_VOLT_RST;
			on_r                        <= 1'b0;
			shutdown_discharge_enable_r <= 1'b0;
			fault_irq_enable_r          <= 1'b0;
			fault_d_r                   <= 1'b0;
		end else begin
			fault_d_r <= fault;
			if (volt_we) begin
				output_level_code_r <= wdata[`LDOREG_VOLT_MSB:0]; // [R1] [R6]
			end
			if (ctrl_we) begin
				on_r                        <= wdata[`LDOREG_CTRL_ON];  // [R2]
				shutdown_discharge_enable_r <= wdata[`LDOREG_CTRL_DIS]; // [R3]
				fault_irq_enable_r          <= wdata[`LDOREG_CTRL_FIE]; // [R4]
			end
		end
	end

	// Reserved bits read zero; power-good is never stored from a write
	assign volt_rd   = {2'b00, output_level_code_r};                          // [R6]
	assign ctrl_rd   = {on_r, 4'b0000, shutdown_discharge_enable_r,
	                    fault_irq_enable_r, pgood};                           // [R5] [R6]
	assign enable    = on_r;
	assign discharge = shutdown_discharge_enable_r & ~on_r;                   // [R3]
	// Rising fault edge only, so a held fault raises one event
	assign fault_evt = fault & ~fault_d_r & fault_irq_enable_r;               // [R4]
endmodule

// ---- sim/ldoreg_properties.sv ----
/* Checker for the regulator register bank.
   Assumes it is bound onto ldoreg_bank and sees only its ports. */
`timescale 1ns/100ps
module ldoreg_props #(parameter NCH = 4) (
	input wire           core_clk,
	input wire           arst_n,
	input wire [7:0]     addr,
	input wire [7:0]     wdata,
	input wire           wr,
	input wire           rd,
	input wire [7:0]     rdata,
	input wire [NCH-1:0] pgood_in,
	input wire [NCH-1:0] fault_in,
	input wire [NCH-1:0] reg_enable,
	input wire [NCH-1:0] reg_discharge,
	input wire           irq
);
	// ----
	// Properties
	// ----
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	wire h_wr = wr && addr == 8'h69;
	wire i_wr = wr && addr[7:4] == 4'hE;
	property p_vres; rd && !addr[0] |=> rdata[7:6] == 2'b00; endproperty
	a_vres: assert property (p_vres) else $error("volt top bits set");
	property p_cres; rd && addr[0] && addr < 8'hA0 |=> rdata[6:3] == 4'h0; endproperty
	a_cres: assert property (p_cres) else $error("ctrl reserved set");
	// Guarded so a second write to the same byte cannot overtake the first
	property p_on; h_wr ##1 !h_wr |=> reg_enable[0] == $past(wdata[7], 2); endproperty
	a_on: assert property (p_on) else $error("enable wrong");
	property p_dis; h_wr && wdata[2] && !wdata[7] ##1 !h_wr |=> reg_discharge[0]; endproperty
	a_dis: assert property (p_dis) else $error("no discharge");
	property p_excl; (reg_enable & reg_discharge) == '0; endproperty
	a_excl: assert property (p_excl) else $error("discharge while on");
	property p_irq; $fell(irq) |-> $past(i_wr) || $past(i_wr, 2); endproperty
	a_irq: assert property (p_irq) else $error("irq dropped alone");
	property p_pg; rd && addr == 8'h69 && pgood_in[0] == $past(pgood_in[0], 4)
		|=> rdata[0] == $past(pgood_in[0]); endproperty
	a_pg: assert property (p_pg) else $error("power good wrong");
	c_irq: cover property ($rose(irq));
	c_dis: cover property ($rose(reg_discharge[0]));
	c_on: cover property ($rose(reg_enable[3]));
endmodule
bind ldoreg_bank ldoreg_props #(.NCH(NCH)) u_props (.core_clk(core_clk), .arst_n(arst_n),
	.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .pgood_in(pgood_in),
	.fault_in(fault_in), .reg_enable(reg_enable), .reg_discharge(reg_discharge), .irq(irq));

// ---- sim/testbench.sv ----
/* Self-checking bench for the regulator register bank.
   Assumes ldoreg_bank and its checker are compiled first. */
`timescale 1ns/100ps
module testbench;
	reg        core_clk, arst_n, wr, rd;
	reg  [7:0] addr, wdata;
	reg  [3:0] pgood_in, fault_in;
	wire [7:0] rdata;
	wire [3:0] reg_enable, reg_discharge;
	wire       irq;
	integer    mismatches, checked, i;
	ldoreg_bank uut (.core_clk(core_clk), .arst_n(arst_n), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .pgood_in(pgood_in), .fault_in(fault_in),
		.reg_enable(reg_enable), .reg_discharge(reg_discharge), .irq(irq));
	// ----
	// Helpers
	// ----
	function [7:0] va(input integer n);
		va = n ? 8'h60 + 8'h10 * n[3:0] : 8'h68;
	endfunction
	task chk(input [7:0] s, input [7:0] e);
		begin
			checked = checked + 1;
			if (s !== e) begin
				mismatches = mismatches + 1;
				$display("BAD %0t seen %h exp %h", $time, s, e);
			end
		end
	endtask
	task wreg(input [7:0] a, input [7:0] d);
		begin
			@(posedge core_clk) begin addr <= a; wdata <= d; wr <= 1'b1; end
			@(posedge core_clk) wr <= 1'b0;
		end
	endtask
	// Read data stand only in the cycle after the strobe
	task rreg(input [7:0] a, input [7:0] e);
		begin
			@(posedge core_clk) begin addr <= a; rd <= 1'b1; end
			@(posedge core_clk) rd <= 1'b0;
			#1 chk(rdata, e);
		end
	endtask
	task close_out;
		begin
			$display("mismatches %0d checked %0d", mismatches, checked);
			if (mismatches == 0 && checked > 0)
				$display("No errors found");
			else
				$display("Errors were found");
			$finish;
		end
	endtask
	// ----
	// Scenarios
	// ----
	task t_volt;
		for (i = 0; i < 4; i = i + 1) begin
			rreg(va(i), 8'h00);
			wreg(va(i), 8'hFF);
			rreg(va(i), 8'h3F);
			wreg(va(i), 8'h2A);
			rreg(va(i), 8'h2A);
		end
	endtask
	task t_ctrl;
		begin
			for (i = 0; i < 4; i = i + 1) begin
				wreg(va(i) + 8'h01, 8'hFF);
				rreg(va(i) + 8'h01, 8'h86);
			end
			chk({4'h0, reg_enable}, 8'h0F);
			for (i = 0; i < 4; i = i + 1) wreg(va(i) + 8'h01, 8'h04);
			repeat (2) @(posedge core_clk) pgood_in <= 4'hF;
			#1;
			chk({4'h0, reg_enable}, 8'h00);
			chk({4'h0, reg_discharge}, 8'h0F);
			repeat (4) @(posedge core_clk);
			for (i = 0; i < 4; i = i + 1) rreg(va(i) + 8'h01, 8'h05);
			wreg(8'h69, 8'h00);
			wreg(8'h55, 8'hFF);
			rreg(8'h55, 8'h00);
			chk({4'h0, reg_discharge}, 8'h0E);
		end
	endtask
	task t_irq;
		begin
			wreg(8'hE1, 8'h0F);
			@(posedge core_clk) fault_in <= 4'h1;
			repeat (6) @(posedge core_clk);
			chk({7'h0, irq}, 8'h00);
			rreg(8'hE0, 8'h00);
			@(posedge core_clk) fault_in <= 4'h0;
			wreg(8'h69, 8'h02);
			@(posedge core_clk) fault_in <= 4'h1;
			repeat (6) @(posedge core_clk);
			#1;
			chk({7'h0, irq}, 8'h01);
			rreg(8'hE0, 8'h01);
			wreg(8'hE1, 8'h00);
			repeat (2) @(posedge core_clk);
			chk({7'h0, irq}, 8'h00);
			wreg(8'hE1, 8'h0F);
			wreg(8'hE0, 8'h01);
			repeat (2) @(posedge core_clk);
			chk({7'h0, irq}, 8'h00);
			rreg(8'hE0, 8'h00);
		end
	endtask
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	initial begin
		#200000;
		mismatches = mismatches + 1;
		close_out;
	end
	initial begin
		mismatches = 0;
		checked = 0;
		{arst_n, wr, rd, addr, wdata, pgood_in, fault_in} = 0;
		repeat (8) @(posedge core_clk);
		arst_n <= 1'b1;
		t_volt;
		t_ctrl;
		t_irq;
		close_out;
	end
endmodule
